/* core/eppr_pkg.sv */
// Constants and types for the EPP 1.7 read engine and ECP register map
package eppr_pkg;
    // Register offsets from the port base
    localparam logic [3:0] EPPR_OFS_DATA = 4'h0;
    localparam logic [3:0] EPPR_OFS_STATUS = 4'h1;
    localparam logic [3:0] EPPR_OFS_CONTROL = 4'h2;
    localparam logic [3:0] EPPR_OFS_EPP_ADDR = 4'h3;
    localparam logic [3:0] EPPR_OFS_EPP_DATA = 4'h4;
    localparam logic [3:0] EPPR_OFS_AFIFO = 4'h5;
    localparam logic [3:0] EPPR_OFS_COMPAT_FIFO = 4'h6;
    localparam logic [3:0] EPPR_OFS_DFIFO = 4'h7;
    localparam logic [3:0] EPPR_OFS_TEST_FIFO = 4'h8;
    localparam logic [3:0] EPPR_OFS_CFGA = 4'h9;
    localparam logic [3:0] EPPR_OFS_CFGB = 4'ha;
    localparam logic [3:0] EPPR_OFS_EXT_CTL = 4'hb;
    // Control and status register fields, and the RLE flag bit
    localparam int EPPR_CTL_STROBE = 0;
    localparam int EPPR_CTL_AUTOFD = 1;
    localparam int EPPR_CTL_INIT_N = 2;
    localparam int EPPR_CTL_SELIN = 3;
    localparam int EPPR_CTL_DIR = 5;
    localparam int EPPR_STS_TIMEOUT = 0;
    localparam int EPPR_RLE_FLAG = 7;
    // Reset values and fixed read values
    localparam logic [7:0] EPPR_CTL_RESET = 8'h04;
    localparam logic [7:0] EPPR_EXT_CTL_RESET = 8'h15;
    localparam logic [7:0] EPPR_CFGA_VALUE = 8'h10;
    localparam logic [7:0] EPPR_UNMAPPED = 8'h00;
    // Watchdog timing and FIFO depth
    localparam int EPPR_CLK_MHZ = 125;
    localparam int EPPR_WDOG_US = 10;
    localparam int EPPR_WDOG_CYCLES = EPPR_WDOG_US * EPPR_CLK_MHZ;
    localparam int EPPR_FIFO_DEPTH = 16;
    typedef enum logic [3:0] {
        EPPR_IDLE = 4'b0001,
        EPPR_STROBE = 4'b0010,
        EPPR_DONE = 4'b0100,
        EPPR_ABORT = 4'b1000
    } eppr_state_type;
endpackage : eppr_pkg

/* core/eppr_port.sv */
// EPP 1.7 read cycle engine with ECP register set
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
module eppr_port
    import eppr_pkg::*;
#(
    parameter int WDOG_CYCLES = EPPR_WDOG_CYCLES,
    parameter int DEPTH = EPPR_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // ISA host cycle
    input wire logic host_ior_n_in,
    input wire logic [3:0] host_addr_in,
    output logic [7:0] host_rdata_out,
    output logic host_chrdy_out,
    // Global configuration
    input wire logic [2:0] cfg_irq_sel_in,
    input wire logic [2:0] cfg_dma_sel_in,
    // Peripheral side
    input wire logic [7:0] peripheral_bus_in,
    output logic [7:0] peripheral_bus_out,
    output logic peripheral_bus_oe_out,
    input wire logic peripheral_hold_n_in,
    input wire logic peripheral_irq_in,
    output logic write_indicator_n_out,
    output logic data_strobe_n_out,
    output logic addr_strobe_n_out,
    output logic bus_direction_out,
    output logic peripheral_reset_n_out,
    output logic peripheral_irq_out,
    output logic irq_rise_out
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and shared FIFO storage
    eppr_state_type state_q;
    logic [7:0] port_data_q;
    logic [7:0] port_control_q;
    logic [7:0] extended_control_q;
    logic timeout_q;
    logic [7:0] fifo_mem_q [DEPTH];
    logic [$clog2(DEPTH)-1:0] wr_ptr_q;
    logic [$clog2(DEPTH)-1:0] rd_ptr_q;
    logic [$clog2(DEPTH):0] count_q;
    logic hold_meta_q;
    logic hold_sync_q;
    logic irq_d1_q;
    logic addr_cycle_q;
    logic [15:0] wdog_q;
    logic [7:0] host_rdata_q;
    logic [7:0] rdata_q;
    logic control_direction_bit;
    logic in_cycle;
    logic fifo_push;
    logic fifo_pop;
    logic fifo_full;
    logic fifo_empty;
    logic [7:0] status_word;
    logic [7:0] config_b;

    function automatic logic is_fifo_ofs(input logic [3:0] a);
        is_fifo_ofs = (a == EPPR_OFS_AFIFO) || (a == EPPR_OFS_COMPAT_FIFO) ||
                      (a == EPPR_OFS_DFIFO) || (a == EPPR_OFS_TEST_FIFO);
    endfunction : is_fifo_ofs

    function automatic logic is_epp_ofs(input logic [3:0] a);
        is_epp_ofs = (a == EPPR_OFS_EPP_ADDR) || (a == EPPR_OFS_EPP_DATA);
    endfunction : is_epp_ofs

    assign control_direction_bit = port_control_q[EPPR_CTL_DIR];
    assign in_cycle = (state_q == EPPR_STROBE);

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser for peripheral hold
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hold_meta_q <= 1'b1;
            hold_sync_q <= 1'b1;
        end else begin
            hold_meta_q <= peripheral_hold_n_in;
            hold_sync_q <= hold_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // EPP 1.7 read cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= EPPR_IDLE;
            addr_cycle_q <= 1'b0;
            wdog_q <= 16'h0000;
            host_rdata_q <= 8'h00;
        end else begin
            case (state_q)
                EPPR_IDLE: begin
                    wdog_q <= 16'h0000;
                    if (!host_ior_n_in && is_epp_ofs(host_addr_in)) begin
                        state_q <= EPPR_STROBE;
                        addr_cycle_q <= (host_addr_in == EPPR_OFS_EPP_ADDR);
                    end
                end
                EPPR_STROBE: begin
                    wdog_q <= wdog_q + 16'h0001;
                    if (host_ior_n_in) begin
                        state_q <= EPPR_IDLE;
                    end else if (32'(wdog_q) >= WDOG_CYCLES - 1) begin
                        state_q <= EPPR_ABORT;
                    end else if (hold_sync_q) begin
                        host_rdata_q <= peripheral_bus_in;
                        state_q <= EPPR_DONE;
                    end
                end
                EPPR_DONE, EPPR_ABORT: begin
                    if (host_ior_n_in) begin
                        state_q <= EPPR_IDLE;
                    end
                end
                default: state_q <= EPPR_IDLE;
            endcase
        end
    end

    // Ready low while hold active in a cycle, released on abort
    assign host_chrdy_out = !(in_cycle && !hold_sync_q);
    assign host_rdata_out = host_rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Peripheral outputs
    logic strobe_active;
    assign strobe_active = (state_q == EPPR_STROBE) || (state_q == EPPR_DONE);
    assign data_strobe_n_out = !(strobe_active && !addr_cycle_q);
    assign addr_strobe_n_out = !(strobe_active && addr_cycle_q);
    // Standard strobe bit forces write indication even during a cycle
    assign write_indicator_n_out = !(port_control_q[EPPR_CTL_STROBE] ||
                                     !control_direction_bit);
    assign bus_direction_out = control_direction_bit || strobe_active;
    assign peripheral_bus_oe_out = !bus_direction_out;
    assign peripheral_bus_out = port_data_q;
    assign peripheral_reset_n_out = port_control_q[EPPR_CTL_INIT_N];
    assign peripheral_irq_out = peripheral_irq_in;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_d1_q <= 1'b0;
        end else begin
            irq_d1_q <= peripheral_irq_in;
        end
    end
    assign irq_rise_out = peripheral_irq_in && !irq_d1_q;

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_data_q <= 8'h00;
            port_control_q <= EPPR_CTL_RESET;
            extended_control_q <= EPPR_EXT_CTL_RESET;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                EPPR_OFS_DATA: port_data_q <= reg_wdata_in;
                EPPR_OFS_CONTROL: port_control_q <= {2'b00, reg_wdata_in[5:0]};
                EPPR_OFS_EXT_CTL: extended_control_q[7:2] <= reg_wdata_in[7:2];
                default: ;
            endcase
        end
    end

    // Timeout is sticky; a new abort wins over a clear by status read
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timeout_q <= 1'b0;
        end else if (in_cycle && !host_ior_n_in && 32'(wdog_q) >= WDOG_CYCLES - 1) begin
            timeout_q <= 1'b1;
        end else if (reg_rd_in && reg_addr_in == EPPR_OFS_STATUS) begin
            timeout_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared FIFO
    assign fifo_full = (count_q == ($clog2(DEPTH)+1)'(DEPTH));
    assign fifo_empty = (count_q == '0);
    assign fifo_push = reg_wr_in && is_fifo_ofs(reg_addr_in) && !fifo_full;
    // Only the readable FIFO views pop; reading a write-only view must not lose a byte
    assign fifo_pop = reg_rd_in && !fifo_empty &&
                      (reg_addr_in == EPPR_OFS_DFIFO || reg_addr_in == EPPR_OFS_TEST_FIFO);

    always_ff @(posedge clk_in) begin
        if (fifo_push) begin
            fifo_mem_q[wr_ptr_q] <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (fifo_push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (fifo_pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (($clog2(DEPTH)+1)'(fifo_push)) -
                       (($clog2(DEPTH)+1)'(fifo_pop));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads
    assign status_word = {!hold_sync_q, 6'h00, timeout_q};
    assign config_b = {1'b0, peripheral_irq_in, cfg_irq_sel_in, cfg_dma_sel_in};

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                EPPR_OFS_DATA: rdata_q <= control_direction_bit ? peripheral_bus_in : port_data_q;
                EPPR_OFS_STATUS: rdata_q <= status_word;
                EPPR_OFS_CONTROL: rdata_q <= port_control_q;
                EPPR_OFS_EPP_ADDR, EPPR_OFS_EPP_DATA: rdata_q <= host_rdata_q;
                EPPR_OFS_DFIFO, EPPR_OFS_TEST_FIFO: rdata_q <= fifo_mem_q[rd_ptr_q];
                EPPR_OFS_CFGA: rdata_q <= EPPR_CFGA_VALUE;
                EPPR_OFS_CFGB: rdata_q <= config_b;
                EPPR_OFS_EXT_CTL: rdata_q <= {extended_control_q[7:2], fifo_full, fifo_empty};
                default: rdata_q <= EPPR_UNMAPPED;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata_out = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_chrdy_low;
        @(posedge clk_in) disable iff (!rst_n_in)
        (in_cycle && !hold_sync_q) |-> !host_chrdy_out;
    endproperty
    a_chrdy_low: assert property (p_chrdy_low) else $error("ready high during hold");

    property p_finish_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        (in_cycle && !host_ior_n_in && $past(in_cycle)) ##1 (state_q == EPPR_DONE)
            |-> $past(hold_sync_q);
    endproperty
    a_finish_hold: assert property (p_finish_hold) else $error("done without hold release");

    property p_strobe_start;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_q == EPPR_IDLE && !host_ior_n_in && is_epp_ofs(host_addr_in))
            |=> (!data_strobe_n_out || !addr_strobe_n_out);
    endproperty
    a_strobe_start: assert property (p_strobe_start) else $error("no strobe after read");

    property p_strobe_drop;
        @(posedge clk_in) disable iff (!rst_n_in)
        (strobe_active && host_ior_n_in) |=> (data_strobe_n_out && addr_strobe_n_out);
    endproperty
    a_strobe_drop: assert property (p_strobe_drop) else $error("strobe held after read");

    property p_one_strobe;
        @(posedge clk_in) disable iff (!rst_n_in)
        !(!data_strobe_n_out && !addr_strobe_n_out);
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");

    property p_dir;
        @(posedge clk_in) disable iff (!rst_n_in)
        bus_direction_out |-> (control_direction_bit || strobe_active);
    endproperty
    a_dir: assert property (p_dir) else $error("direction high without cause");

    property p_release;
        @(posedge clk_in) disable iff (!rst_n_in)
        control_direction_bit |-> (!peripheral_bus_oe_out &&
            (write_indicator_n_out || port_control_q[EPPR_CTL_STROBE]));
    endproperty
    a_release: assert property (p_release) else $error("bus driven in read direction");

    property p_timeout;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_q == EPPR_ABORT && $past(in_cycle)) |-> timeout_q;
    endproperty
    a_timeout: assert property (p_timeout) else $error("abort without timeout flag");

    property p_sync;
        @(posedge clk_in) disable iff (!rst_n_in)
        $past(rst_n_in, 2) |-> (hold_sync_q == $past(peripheral_hold_n_in, 2));
    endproperty
    a_sync: assert property (p_sync) else $error("hold not synchronised");

    property p_irq_edge;
        @(posedge clk_in) disable iff (!rst_n_in)
        irq_rise_out |=> !irq_rise_out;
    endproperty
    a_irq_edge: assert property (p_irq_edge) else $error("edge pulse too long");

    property p_abort_release;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_q == EPPR_ABORT) |-> (host_chrdy_out && data_strobe_n_out && addr_strobe_n_out);
    endproperty
    a_abort_release: assert property (p_abort_release) else $error("abort kept cycle");

    c_done: cover property (@(posedge clk_in) state_q == EPPR_DONE);
    c_abort: cover property (@(posedge clk_in) state_q == EPPR_ABORT);
    c_addr: cover property (@(posedge clk_in) !addr_strobe_n_out);
    c_full: cover property (@(posedge clk_in) fifo_full);

endmodule : eppr_port

/* test/eppr_periph.sv */
// Peripheral model that answers EPP read strobes with data and the hold handshake
`timescale 1ns/1ns
module eppr_periph (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Strobes from the port
    input wire logic data_strobe_n_in,
    input wire logic addr_strobe_n_in,
    // Scenario settings, delay 8'hff stalls for good
    input wire logic [7:0] data_byte_in,
    input wire logic [7:0] addr_byte_in,
    input wire logic [7:0] delay_in,
    // Peripheral pins
    output logic [7:0] bus_out,
    output logic hold_n_out
);
    logic [7:0] count_q;
    logic [7:0] last_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q <= 8'h00;
            last_q <= 8'h00;
            bus_out <= 8'hff;
            hold_n_out <= 1'b0;
        end else if (!data_strobe_n_in || !addr_strobe_n_in) begin
            if (count_q != 8'hff) begin
                count_q <= count_q + 8'h01;
            end
            if (count_q == delay_in) begin
                bus_out <= data_strobe_n_in ? addr_byte_in : data_byte_in;
                last_q <= data_strobe_n_in ? addr_byte_in : data_byte_in;
            end
            if (count_q > delay_in) begin
                hold_n_out <= 1'b1;
            end
        end else begin
            count_q <= 8'h00;
            hold_n_out <= 1'b0;
            // Released bus shows no stale value
            bus_out <= ~last_q;
        end
    end
endmodule : eppr_periph

/* test/tb.sv */
// Self-checking testbench for the EPP read engine and register map
`timescale 1ns/1ns
module tb;
    import eppr_pkg::*;
    localparam int WDOG = 20;
    logic clk_in, rst_n_in, reg_wr_in, reg_rd_in, host_ior_n_in, irq_in;
    logic [3:0] reg_addr_in, host_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, host_rdata_out, pbus_in, pbus_out, delay_q;
    logic chrdy, oe, hold_n, wi_n, ds_n, as_n, dir, prst_n, irq_out, irq_rise, dir_bit;
    int err_total, samples_checked;

    eppr_port #(.WDOG_CYCLES(WDOG), .DEPTH(16)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .host_ior_n_in(host_ior_n_in),
        .host_addr_in(host_addr_in), .host_rdata_out(host_rdata_out), .host_chrdy_out(chrdy),
        .cfg_irq_sel_in(3'h5), .cfg_dma_sel_in(3'h2), .peripheral_bus_in(pbus_in),
        .peripheral_bus_out(pbus_out), .peripheral_bus_oe_out(oe),
        .peripheral_hold_n_in(hold_n), .peripheral_irq_in(irq_in),
        .write_indicator_n_out(wi_n), .data_strobe_n_out(ds_n), .addr_strobe_n_out(as_n),
        .bus_direction_out(dir), .peripheral_reset_n_out(prst_n),
        .peripheral_irq_out(irq_out), .irq_rise_out(irq_rise));
    eppr_periph periph (.clk_in(clk_in), .rst_n_in(rst_n_in), .data_strobe_n_in(ds_n),
        .addr_strobe_n_in(as_n), .data_byte_in(8'h5a), .addr_byte_in(8'ha3),
        .delay_in(delay_q), .bus_out(pbus_in), .hold_n_out(hold_n));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
    endtask : reg_rd

    task automatic host_read(input logic [3:0] a, input logic [7:0] dly, input logic [7:0] exp,
                             input logic use_addr);
        int n;
        @(posedge clk_in);
        delay_q <= dly;
        host_addr_in <= a;
        host_ior_n_in <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (ds_n && as_n && n < 10);
        chk({7'h0, ds_n}, {7'h0, use_addr});
        chk({7'h0, as_n}, {7'h0, !use_addr});
        chk({7'h0, dir}, 8'h01);
        chk({7'h0, chrdy}, 8'h00);
        n = 0;
        while (chrdy !== 1'b1 && n < 100) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk({7'h0, hold_n}, 8'h01);
        chk({7'h0, ds_n & as_n}, 8'h00);
        @(posedge clk_in);
        host_ior_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk({6'h0, ds_n, as_n}, 8'h03);
        chk(host_rdata_out, exp);
        chk({7'h0, dir}, {7'h0, dir_bit});
    endtask : host_read

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        chk({ds_n, as_n, chrdy, prst_n, dir, wi_n, 2'b00}, 8'hf0);
        reg_rd(EPPR_OFS_CONTROL, EPPR_CTL_RESET);
        reg_wr(EPPR_OFS_DATA, 8'h69);
        #1;
        chk(pbus_out, 8'h69);
        chk({7'h0, oe}, 8'h01);
        reg_rd(EPPR_OFS_DATA, 8'h69);
        reg_wr(EPPR_OFS_CFGA, 8'hff);
        reg_rd(EPPR_OFS_CFGA, 8'h10);
        reg_rd(EPPR_OFS_EXT_CTL, 8'h15);
        reg_rd(EPPR_OFS_CFGB, 8'h2a);
        reg_rd(4'hc, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task automatic t_epp;
        host_read(EPPR_OFS_EPP_DATA, 8'h03, 8'h5a, 1'b0);
        reg_wr(EPPR_OFS_CONTROL, 8'he4);
        dir_bit = 1'b1;
        reg_rd(EPPR_OFS_CONTROL, 8'h24);
        chk({6'h0, wi_n, oe}, 8'h02);
        host_read(EPPR_OFS_EPP_ADDR, 8'h06, 8'ha3, 1'b1);
        host_read(EPPR_OFS_EPP_DATA, 8'h02, 8'h5a, 1'b0);
        reg_rd(EPPR_OFS_EPP_DATA, 8'h5a);
        reg_rd(EPPR_OFS_DATA, 8'ha5);
        reg_wr(EPPR_OFS_CONTROL, 8'h21);
        #1;
        chk({7'h0, wi_n}, 8'h00);
        reg_wr(EPPR_OFS_CONTROL, 8'h20);
        #1;
        chk({7'h0, prst_n}, 8'h00);
        reg_wr(EPPR_OFS_CONTROL, 8'h24);
        $display("test epp done");
    endtask : t_epp

    task automatic t_timeout;
        @(posedge clk_in);
        delay_q <= 8'hff;
        host_addr_in <= EPPR_OFS_EPP_DATA;
        host_ior_n_in <= 1'b0;
        repeat (WDOG + 6) @(posedge clk_in);
        #1;
        chk({6'h0, ds_n, chrdy}, 8'h03);
        @(posedge clk_in);
        host_ior_n_in <= 1'b1;
        reg_rd(EPPR_OFS_STATUS, 8'h81);
        reg_rd(EPPR_OFS_STATUS, 8'h80);
        $display("test timeout done");
    endtask : t_timeout

    task automatic t_irq;
        int pulses;
        pulses = 0;
        @(posedge clk_in);
        irq_in <= 1'b1;
        repeat (5) begin
            #1;
            pulses += int'(irq_rise === 1'b1);
            @(posedge clk_in);
        end
        chk(8'(pulses), 8'h01);
        chk({7'h0, irq_out}, 8'h01);
        reg_rd(EPPR_OFS_CFGB, 8'h6a);
        @(posedge clk_in);
        irq_in <= 1'b0;
        $display("test irq done");
    endtask : t_irq

    task automatic t_fifo;
        for (int i = 0; i < 15; i++) reg_wr(EPPR_OFS_TEST_FIFO, 8'h10 + 8'(i));
        reg_wr(EPPR_OFS_AFIFO, 8'h85);
        reg_wr(EPPR_OFS_TEST_FIFO, 8'hee);
        reg_rd(EPPR_OFS_EXT_CTL, 8'h16);
        for (int i = 0; i < 15; i++) reg_rd(EPPR_OFS_TEST_FIFO, 8'h10 + 8'(i));
        reg_rd(EPPR_OFS_TEST_FIFO, 8'h85);
        reg_rd(EPPR_OFS_EXT_CTL, 8'h15);
        $display("test fifo done");
    endtask : t_fifo

    task automatic close_out;
        $display("checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    initial begin
        #(8 * 20000);
        err_total++;
        close_out();
    end

    initial begin
        err_total = 0;
        samples_checked = 0;
        rst_n_in = 1'b0;
        {reg_wr_in, reg_rd_in, irq_in, dir_bit} = 4'h0;
        host_ior_n_in = 1'b1;
        reg_addr_in = 4'h0;
        host_addr_in = 4'h0;
        reg_wdata_in = 8'h00;
        delay_q = 8'h03;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        t_regs();
        t_epp();
        t_timeout();
        t_irq();
        t_fifo();
        close_out();
    end
endmodule : tb
